// *** src/fpxe_pkg.sv ***
// Constants and types shared by the floating-point exception unit
package fpxe_pkg;
	// Register byte offsets on the APB
	localparam logic [11:0] ADDR_CTL = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	// Bit positions in control and status words
	localparam int BIT_INV       = 0;
	localparam int BIT_DIVZERO   = 2;
	localparam int BIT_OE        = 3;
	localparam int BIT_UNDERFLOW = 4;
	localparam int BIT_ROUNDUP   = 9;
	localparam int PC_LO         = 8;
	localparam int RC_LO         = 10;
	// Reset values and writable bits
	localparam logic [15:0] CTL_RST    = 16'h037F;
	localparam logic [15:0] CTL_WMASK  = 16'h0F3F;
	localparam logic [15:0] STAT_RST   = 16'h0000;
	localparam logic [15:0] STAT_WMASK = 16'h021D;
	// Precision and rounding control codes
	localparam logic [1:0] PC_SGL  = 2'h0;
	localparam logic [1:0] PC_DBL  = 2'h2;
	localparam logic [1:0] PC_EXT  = 2'h3;
	localparam logic [1:0] RC_NEAR = 2'h0;
	localparam logic [1:0] RC_DOWN = 2'h1;
	localparam logic [1:0] RC_UP   = 2'h2;
	localparam logic [1:0] RC_ZERO = 2'h3;
	// Position of the kept lsb in the 67-bit significand
	localparam logic [6:0] RL_SGL = 7'h2B;
	localparam logic [6:0] RL_DBL = 7'h0E;
	localparam logic [6:0] RL_EXT = 7'h03;
	// Largest significands per precision
	localparam logic [63:0] MAXS_SGL = 64'hFFFF_FF00_0000_0000;
	localparam logic [63:0] MAXS_DBL = 64'hFFFF_FFFF_FFFF_F800;
	localparam logic [63:0] MAXS_EXT = 64'hFFFF_FFFF_FFFF_FFFF;
	localparam logic [63:0] SIG_INT  = 64'h8000_0000_0000_0000;
	localparam logic [14:0] EXP_INF  = 15'h7FFF;
	localparam logic [14:0] EXP_ONE  = 15'h3FFF;
	// Operation classes
	localparam logic [2:0] OP_ARITH  = 3'h0;
	localparam logic [2:0] OP_DIV    = 3'h1;
	localparam logic [2:0] OP_LOG    = 3'h2;
	localparam logic [2:0] OP_XTRACT = 3'h3;
	localparam logic [2:0] OP_SCALE  = 3'h4;
	localparam logic [2:0] OP_FSTORE = 3'h5;
	localparam logic [2:0] OP_ISTORE = 3'h6;
	localparam logic FMT_SGL = 1'h0;
	// Unbiased exponent limits and biases
	localparam logic signed [17:0] EMAX_EXT = 18'sh0_3FFF;
	localparam logic signed [17:0] EMIN_EXT = -18'sh0_3FFE;
	localparam logic signed [17:0] EMAX_DBL = 18'sh0_03FF;
	localparam logic signed [17:0] EMIN_DBL = -18'sh0_03FE;
	localparam logic signed [17:0] EMAX_SGL = 18'sh0_007F;
	localparam logic signed [17:0] EMIN_SGL = -18'sh0_007E;
	localparam logic signed [17:0] BIAS_EXT = 18'sh0_3FFF;
	localparam logic signed [17:0] REBIAS   = 18'sh0_6000;
	localparam logic signed [17:0] EB_MAX   = 18'sh0_7FFE;
	localparam logic signed [17:0] EB_MIN   = 18'sh0_0001;
	localparam logic signed [17:0] SH_MAX   = 18'sh0_003F;

	typedef struct packed {
		logic               valid;
		logic [2:0]         op;
		logic               mem_dst;
		logic               mem_fmt;
		logic               pc_ignore;
		logic               sa;
		logic               sb;
		logic               za;
		logic               zb;
		logic               fa;
		logic               rnum;
		logic               rs;
		logic signed [17:0] rexp;
		logic [66:0]        rsig;
	} fpxe_op_t;

	typedef struct packed {
		logic        wr_top;
		logic        wr_mem;
		logic        wr_second;
		logic [79:0] top_val;
		logic [79:0] second_val;
	} fpxe_res_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_RAISE = 2'b10
	} fpxe_st_t;

	typedef struct packed {
		fpxe_st_t    state;
		logic        ready;
		fpxe_res_t   res;
		logic        hnd;
		logic [15:0] ctl;
		logic [15:0] stat;
		logic [15:0] pflag;
		logic        pc1;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} fpxe_state_t;
endpackage : fpxe_pkg

// *** src/fpxe_round.sv ***
// Significand rounder for the exception unit
module fpxe_round (
	// Operand
	input  wire logic        sign,
	input  wire logic [66:0] sig_in,
	// Controls
	input  wire logic [1:0]  prec,
	input  wire logic [1:0]  rmode,
	// Result
	output logic      [63:0] sig_out,
	output logic             carry,
	output logic             up
);
	logic [6:0]  lsb_pos;
	logic [66:0] unit;
	logic [66:0] keep;
	logic [67:0] sum;
	logic        lbit;
	logic        rbit;
	logic        sticky;

	always_comb begin
		case (prec)
			fpxe_pkg::PC_SGL: lsb_pos = fpxe_pkg::RL_SGL;
			fpxe_pkg::PC_DBL: lsb_pos = fpxe_pkg::RL_DBL;
			default:          lsb_pos = fpxe_pkg::RL_EXT;
		endcase
	end

	assign unit   = 67'h1 << lsb_pos;
	assign keep   = ~(unit - 67'h1);
	assign lbit   = |(sig_in & unit);
	assign rbit   = |(sig_in & (unit >> 1));
	assign sticky = |(sig_in & ((unit >> 1) - 67'h1));

	always_comb begin
		case (rmode)
			fpxe_pkg::RC_NEAR: up = rbit & (sticky | lbit);
			fpxe_pkg::RC_DOWN: up = sign & (rbit | sticky);
			fpxe_pkg::RC_UP:   up = ~sign & (rbit | sticky);
			default:           up = 1'b0;
		endcase
	end

	assign sum     = {1'b0, sig_in & keep} + (up ? {1'b0, unit} : 68'h0);
	assign carry   = sum[67];
	assign sig_out = carry ? fpxe_pkg::SIG_INT : sum[66:3];
endmodule : fpxe_round

// *** src/fpxe_exc.sv ***
// Divide-by-zero, overflow and underflow exception unit
// What this block does
// - Flag divide-by-zero when a finite non-zero operand is divided by zero.
// - Divide-by-zero flag is status bit 2, its mask control bit 2.
// - Divides, integer divides, log and exponent-extract can all report divide-by-zero.
// - Always set the flag; masked writes result, unmasked calls handler, no write.
// - Masked divide by zero gives infinity signed by XOR of operand signs.
// - Masked log by zero gives infinity opposite in sign to the non-zero operand.
// - Masked extract: second register minus infinity, top zero with source sign.
// - Overflow when rounded result exceeds largest finite value of destination format.
// - Overflow checked for register and float stores; integer stores raise invalid.
// - Overflow flag is status bit 3, its mask control bit 3.
// - Masked overflow sets the flag and writes a rounding-mode chosen value.
// - Unmasked overflow to memory sets flag, clears round-up bit, calls handler, writes nothing.
// - Unmasked overflow to register: round, exponent minus 24576, store, then flag.
// - Unmasked register result sets round-up bit if rounded up, else clears it.
// - Register results of operations ignoring precision control round to double-extended precision; memory stores round to the store format.
// - Scale still overflowing after rebias stores a signed infinity.
// - Underflow when rounded result is below smallest normal of destination format.
// - Integer stores never underflow; tiny values become 0 or 1 by rounding.
// - Underflow flag is status bit 4, its mask control bit 4.
// - Unmasked underflow to memory sets flag, calls handler, writes nothing.
// - Unmasked underflow to register: round, exponent plus 24576, store, then flag.
// - Scale still underflowing after rebias stores a signed zero.
// - The round-up bit is status bit 9.
module fpxe_exc (
	// Clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Operation from the arithmetic core
	input  wire fpxe_pkg::fpxe_op_t  op,
	output logic                     op_ready,
	// Result and handler request
	output fpxe_pkg::fpxe_res_t      res,
	output logic                     handler_req,
	output logic      [15:0]         ctl_word,
	output logic      [15:0]         stat_word
);
	fpxe_pkg::fpxe_state_t st_q;
	fpxe_pkg::fpxe_state_t st_d;

	logic               take;
	logic               divzero_mask;
	logic               overflow_mask;
	logic               underflow_mask;
	logic [1:0]         prec;
	logic [1:0]         rmode;
	logic [63:0]        rsig;
	logic               rcarry;
	logic               rup;
	logic signed [17:0] e;
	logic signed [17:0] emax;
	logic signed [17:0] emin;
	logic signed [17:0] eb_ovf;
	logic signed [17:0] eb_unf;
	logic signed [17:0] sh;
	logic [63:0]        maxs;
	logic               is_div;
	logic               dz;
	logic               ovf;
	logic               unf;
	logic               tiny_int;
	logic               to_inf;
	logic               apb_wr;

	assign take           = op.valid & st_q.ready;
	assign divzero_mask   = st_q.ctl[fpxe_pkg::BIT_DIVZERO];
	assign overflow_mask  = st_q.ctl[fpxe_pkg::BIT_OE];
	assign underflow_mask = st_q.ctl[fpxe_pkg::BIT_UNDERFLOW];
	assign rmode          = st_q.ctl[fpxe_pkg::RC_LO +: 2];
	assign apb_wr         = psel & penable & pwrite & st_q.pready;

	// Precision: store format, or extended for operations that ignore control
	always_comb begin
		if (op.mem_dst) begin
			prec = (op.mem_fmt == fpxe_pkg::FMT_SGL) ? fpxe_pkg::PC_SGL : fpxe_pkg::PC_DBL;
			emax = (op.mem_fmt == fpxe_pkg::FMT_SGL) ? fpxe_pkg::EMAX_SGL : fpxe_pkg::EMAX_DBL;
			emin = (op.mem_fmt == fpxe_pkg::FMT_SGL) ? fpxe_pkg::EMIN_SGL : fpxe_pkg::EMIN_DBL;
		end else begin
			prec = op.pc_ignore ? fpxe_pkg::PC_EXT : st_q.ctl[fpxe_pkg::PC_LO +: 2];
			emax = fpxe_pkg::EMAX_EXT;
			emin = fpxe_pkg::EMIN_EXT;
		end
		case (prec)
			fpxe_pkg::PC_SGL: maxs = fpxe_pkg::MAXS_SGL;
			fpxe_pkg::PC_DBL: maxs = fpxe_pkg::MAXS_DBL;
			default:          maxs = fpxe_pkg::MAXS_EXT;
		endcase
	end

	fpxe_round u_round (
		.sign    (op.rs),
		.sig_in  (op.rsig),
		.prec    (prec),
		.rmode   (rmode),
		.sig_out (rsig),
		.carry   (rcarry),
		.up      (rup)
	);

	assign e      = op.rexp + $signed({17'h0, rcarry});
	assign eb_ovf = e - fpxe_pkg::REBIAS + fpxe_pkg::BIAS_EXT;
	assign eb_unf = e + fpxe_pkg::REBIAS + fpxe_pkg::BIAS_EXT;
	assign sh     = emin - e;
	assign to_inf = (rmode == fpxe_pkg::RC_NEAR) | ((rmode == fpxe_pkg::RC_UP) & ~op.rs)
		| ((rmode == fpxe_pkg::RC_DOWN) & op.rs);

	// Condition detection
	assign is_div   = (op.op == fpxe_pkg::OP_DIV) | (op.op == fpxe_pkg::OP_LOG);
	assign dz       = (is_div & op.zb & op.fa & ~op.za)
		| ((op.op == fpxe_pkg::OP_XTRACT) & op.za);
	assign ovf      = ~dz & op.rnum & (op.op != fpxe_pkg::OP_ISTORE)
		& (op.op != fpxe_pkg::OP_XTRACT) & (e > emax);
	assign unf      = ~dz & op.rnum & (op.op != fpxe_pkg::OP_ISTORE)
		& (op.op != fpxe_pkg::OP_XTRACT) & (e < emin);
	assign tiny_int = (op.op == fpxe_pkg::OP_ISTORE) & op.rnum & op.rexp[17];

	always_comb begin
		st_d             = st_q;
		st_d.res.wr_top  = 1'b0;
		st_d.res.wr_mem  = 1'b0;
		st_d.res.wr_second = 1'b0;
		st_d.hnd         = 1'b0;
		st_d.pready      = psel & ~penable & ~st_q.pready;
		// APB register access
		if (psel & ~penable & ~st_q.pready) begin
			st_d.pslverr = (paddr != fpxe_pkg::ADDR_CTL) & (paddr != fpxe_pkg::ADDR_STAT);
			case (paddr)
				fpxe_pkg::ADDR_CTL:  st_d.prdata = {16'h0, st_q.ctl};
				fpxe_pkg::ADDR_STAT: st_d.prdata = {16'h0, st_q.stat};
				default:             st_d.prdata = 32'h0;
			endcase
		end else if (st_q.pready) begin
			st_d.pslverr = 1'b0;
			st_d.prdata  = 32'h0;
		end
		if (apb_wr & (paddr == fpxe_pkg::ADDR_CTL)) begin
			st_d.ctl = pwdata[15:0] & fpxe_pkg::CTL_WMASK;
		end
		if (apb_wr & (paddr == fpxe_pkg::ADDR_STAT)) begin
			st_d.stat = pwdata[15:0] & fpxe_pkg::STAT_WMASK;
		end
		// Operation handling; flag sets below win over software writes
		case (st_q.state)
			fpxe_pkg::ST_IDLE: begin
				if (take) begin
					st_d.res.top_val    = {op.rs, 15'(e + fpxe_pkg::BIAS_EXT), rsig};
					st_d.res.second_val = 80'h0;
					if (dz) begin
						st_d.stat[fpxe_pkg::BIT_DIVZERO] = 1'b1;
						if (!divzero_mask) begin
							st_d.hnd = 1'b1;
						end else if (op.op == fpxe_pkg::OP_XTRACT) begin
							st_d.res.top_val    = {op.sa, 79'h0};
							st_d.res.second_val = {1'b1, fpxe_pkg::EXP_INF, fpxe_pkg::SIG_INT};
							st_d.res.wr_top     = 1'b1;
							st_d.res.wr_second  = 1'b1;
						end else begin
							st_d.res.top_val = (op.op == fpxe_pkg::OP_LOG)
								? {~op.sa, fpxe_pkg::EXP_INF, fpxe_pkg::SIG_INT}
								: {op.sa ^ op.sb, fpxe_pkg::EXP_INF, fpxe_pkg::SIG_INT};
							st_d.res.wr_top  = ~op.mem_dst;
							st_d.res.wr_mem  = op.mem_dst;
						end
					end else if (ovf) begin
						if (overflow_mask) begin
							st_d.stat[fpxe_pkg::BIT_OE] = 1'b1;
							st_d.res.top_val = to_inf ? {op.rs, fpxe_pkg::EXP_INF, fpxe_pkg::SIG_INT}
								: {op.rs, 15'(emax + fpxe_pkg::BIAS_EXT), maxs};
							st_d.res.wr_top  = ~op.mem_dst;
							st_d.res.wr_mem  = op.mem_dst;
						end else if (op.mem_dst) begin
							st_d.stat[fpxe_pkg::BIT_OE] = 1'b1;
							st_d.stat[fpxe_pkg::BIT_ROUNDUP] = 1'b0;
							st_d.hnd = 1'b1;
						end else begin
							st_d.res.top_val = ((op.op == fpxe_pkg::OP_SCALE) && (eb_ovf > fpxe_pkg::EB_MAX))
								? {op.rs, fpxe_pkg::EXP_INF, fpxe_pkg::SIG_INT}
								: {op.rs, eb_ovf[14:0], rsig};
							st_d.res.wr_top  = 1'b1;
							st_d.pflag       = 16'h1 << fpxe_pkg::BIT_OE;
							st_d.pc1         = rup;
							st_d.state       = fpxe_pkg::ST_RAISE;
						end
					end else if (unf) begin
						if (underflow_mask) begin
							st_d.stat[fpxe_pkg::BIT_UNDERFLOW] = 1'b1;
							st_d.res.top_val = (sh > fpxe_pkg::SH_MAX) ? {op.rs, 79'h0}
								: {op.rs, op.mem_dst ? 15'(emin + fpxe_pkg::BIAS_EXT) : 15'h0,
								rsig >> sh[5:0]};
							st_d.res.wr_top  = ~op.mem_dst;
							st_d.res.wr_mem  = op.mem_dst;
						end else if (op.mem_dst) begin
							st_d.stat[fpxe_pkg::BIT_UNDERFLOW] = 1'b1;
							st_d.stat[fpxe_pkg::BIT_ROUNDUP] = 1'b0;
							st_d.hnd = 1'b1;
						end else begin
							st_d.res.top_val = ((op.op == fpxe_pkg::OP_SCALE) && (eb_unf < fpxe_pkg::EB_MIN))
								? {op.rs, 79'h0}
								: {op.rs, eb_unf[14:0], rsig};
							st_d.res.wr_top  = 1'b1;
							st_d.pflag       = 16'h1 << fpxe_pkg::BIT_UNDERFLOW;
							st_d.pc1         = rup;
							st_d.state       = fpxe_pkg::ST_RAISE;
						end
					end else begin
						if ((op.op == fpxe_pkg::OP_ISTORE) && op.rnum && (e > emax)) begin
							st_d.stat[fpxe_pkg::BIT_INV] = 1'b1;
						end
						if (tiny_int) begin
							st_d.res.top_val = (((rmode == fpxe_pkg::RC_UP) & ~op.rs)
								| ((rmode == fpxe_pkg::RC_DOWN) & op.rs))
								? {op.rs, fpxe_pkg::EXP_ONE, fpxe_pkg::SIG_INT}
								: {op.rs, 79'h0};
						end
						st_d.res.wr_top = ~op.mem_dst;
						st_d.res.wr_mem = op.mem_dst;
					end
				end
			end
			fpxe_pkg::ST_RAISE: begin
				st_d.stat = st_d.stat | st_q.pflag;
				st_d.stat[fpxe_pkg::BIT_ROUNDUP] = st_q.pc1;
				st_d.hnd   = 1'b1;
				st_d.state = fpxe_pkg::ST_IDLE;
			end
			default: begin
				st_d.state = fpxe_pkg::ST_IDLE;
			end
		endcase
		st_d.ready = (st_d.state == fpxe_pkg::ST_IDLE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= '0;
			st_q.state <= fpxe_pkg::ST_IDLE;
			st_q.ready <= 1'b1;
			st_q.ctl   <= fpxe_pkg::CTL_RST;
			st_q.stat  <= fpxe_pkg::STAT_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata      = st_q.prdata;
	assign pready      = st_q.pready;
	assign pslverr     = st_q.pslverr;
	assign op_ready    = st_q.ready;
	assign res         = st_q.res;
	assign handler_req = st_q.hnd;
	assign ctl_word    = st_q.ctl;
	assign stat_word   = st_q.stat;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_dz_flag_set: assert property (take && dz |=> stat_word[2])
		else $error("divide-by-zero flag not set");
	chk_dz_unmask_keep: assert property (take && dz && !divzero_mask
		|=> handler_req && !res.wr_top && !res.wr_mem && !res.wr_second)
		else $error("unmasked divide-by-zero wrote a result");
	chk_div_sign: assert property (take && dz && divzero_mask && op.op == fpxe_pkg::OP_DIV
		|=> res.top_val[79] == $past(op.sa ^ op.sb) && res.top_val[78:64] == 15'h7FFF)
		else $error("masked divide result sign or exponent wrong");
	chk_xtract_second: assert property (take && dz && divzero_mask && op.op == fpxe_pkg::OP_XTRACT
		|=> res.wr_second && res.second_val[79] && res.top_val[78:0] == 79'h0)
		else $error("masked extract result wrong");
	chk_ovf_mem_keep: assert property (take && ovf && !overflow_mask && op.mem_dst
		|=> handler_req && !res.wr_mem && !res.wr_top && stat_word[3])
		else $error("unmasked overflow to memory changed state");
	chk_reg_order: assert property (take && (ovf || unf) && !op.mem_dst
		&& !(ovf ? overflow_mask : underflow_mask)
		|=> res.wr_top && !handler_req ##1 handler_req && !op_ready == 1'b0)
		else $error("register result not stored before handler request");
	chk_c1_roundup: assert property (take && (ovf || unf) && !op.mem_dst
		&& !(ovf ? overflow_mask : underflow_mask)
		|-> ##2 stat_word[9] == $past(rup, 2))
		else $error("round-up bit does not follow rounding");
	chk_unf_mem_keep: assert property (take && unf && !underflow_mask && op.mem_dst
		|=> handler_req && !res.wr_mem && stat_word[4])
		else $error("unmasked underflow to memory stored a result");
	chk_int_no_ovf: assert property (take && op.op == fpxe_pkg::OP_ISTORE && !stat_word[3]
		&& !(apb_wr && paddr == fpxe_pkg::ADDR_STAT) |=> !stat_word[3] && !handler_req)
		else $error("integer store raised overflow");

	// Condition checks: flags, results and handshake
	chk_ovf_mask_flag: assert property (
		take && ovf && overflow_mask
		|=> stat_word[3] && !handler_req)
		else $error("masked overflow");
	chk_unf_mask_flag: assert property (
		take && unf && underflow_mask
		|=> stat_word[4] && !handler_req)
		else $error("masked underflow");
	chk_log_sign: assert property (
		take && dz && divzero_mask && op.op == fpxe_pkg::OP_LOG
		|=> res.top_val[79] != $past(op.sa))
		else $error("masked log sign");
	chk_xtract_top: assert property (
		take && dz && divzero_mask && op.op == fpxe_pkg::OP_XTRACT
		|=> res.top_val[79] == $past(op.sa) && res.second_val[78:64] == 15'h7FFF)
		else $error("masked extract values");
	chk_dz_mask_write: assert property (
		take && dz && divzero_mask
		|=> (res.wr_top || res.wr_mem) && !handler_req)
		else $error("masked divide-by-zero");
	chk_second_pair: assert property (
		res.wr_second
		|-> res.wr_top && res.second_val[79])
		else $error("second register write");
	chk_int_no_unf: assert property (
		take && op.op == fpxe_pkg::OP_ISTORE && !stat_word[4]
		&& !(apb_wr && paddr == fpxe_pkg::ADDR_STAT) |=> !stat_word[4])
		else $error("integer store underflow");
	chk_ovf_mem_c1: assert property (
		take && ovf && !overflow_mask && op.mem_dst
		|=> !stat_word[9])
		else $error("round-up bit kept");
	chk_unf_mem_c1: assert property (
		take && unf && !underflow_mask && op.mem_dst
		|=> !stat_word[9])
		else $error("round-up bit kept");
	chk_ovf_flag_late: assert property (
		take && ovf && !overflow_mask && !op.mem_dst && !apb_wr
		&& !stat_word[3] |=> !stat_word[3] ##1 stat_word[3])
		else $error("overflow flag timing");
	chk_unf_flag_late: assert property (
		take && unf && !underflow_mask && !op.mem_dst && !apb_wr
		&& !stat_word[4] |=> !stat_word[4] ##1 stat_word[4])
		else $error("underflow flag timing");
	chk_unf_mem_top: assert property (
		take && unf && !underflow_mask && op.mem_dst
		|=> !res.wr_top && !res.wr_second)
		else $error("unmasked underflow wrote");
endmodule : fpxe_exc

// *** verification/fpxe_exc_test.sv ***
// Self-checking testbench for the divide-by-zero, overflow and underflow exception unit
module fpxe_exc_test;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [3:0]  p;
		logic [79:0] top;
		logic [79:0] sec;
	} fpxe_note_t;

	typedef struct packed {
		logic        err;
		logic [31:0] val;
		logic [31:0] msk;
	} fpxe_rd_t;

	localparam logic [63:0] SI = fpxe_pkg::SIG_INT;
	localparam logic [14:0] EI = fpxe_pkg::EXP_INF;

	logic                pclk       = 1'b0;
	logic                presetn    = 1'b0;
	logic                psel       = 1'b0;
	logic                penable    = 1'b0;
	logic                pwrite     = 1'b0;
	logic [11:0]         paddr      = 12'h000;
	logic [31:0]         pwdata     = 32'h0000_0000;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	fpxe_pkg::fpxe_op_t  op         = '0;
	logic                op_ready;
	fpxe_pkg::fpxe_res_t res;
	logic                handler_req;
	logic [15:0]         ctl_word;
	logic [15:0]         stat_word;
	logic                sa, sb, rs;
	logic                ign        = 1'b0;
	fpxe_note_t          nq[$];
	fpxe_rd_t            rq[$];
	int                  num_errors = 0;
	int                  num_checks = 0;
	int                  cycles     = 0;

	always #2.5 pclk = ~pclk;

	fpxe_exc dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op(op),
		.op_ready(op_ready), .res(res), .handler_req(handler_req), .ctl_word(ctl_word), .stat_word(stat_word));

	task automatic end_of_test();
		$display("Errors %0d, checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_reg

	task automatic cmp_res(input logic [79:0] got, input logic [79:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_res

	// Result watcher: takes the oldest note whenever an answer appears, unless ign is set and no handler is requested
	always @(posedge pclk) begin : watch
		fpxe_rd_t   r;
		fpxe_note_t n;
		logic [3:0] ev;
		ev = {res.wr_top, res.wr_mem, res.wr_second, handler_req};
		if (psel && penable && pready) begin
			r = rq.pop_front();
			cmp_reg({31'h0, pslverr}, {31'h0, r.err});
			cmp_reg(prdata & r.msk, r.val & r.msk);
		end
		if (ev !== 4'h0 && !(ign && handler_req === 1'b0)) begin
			n = '0;
			if (nq.size() != 0)
				n = nq.pop_front();
			cmp_res({76'h0, ev}, {76'h0, n.p});
			if (n.p[3] | n.p[2])
				cmp_res(res.top_val, n.top);
			if (n.p[1])
				cmp_res(res.second_val, n.sec);
		end
	end

	// Hang guard
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [15:0] e,
			input logic [15:0] m, input logic err);
		rq.push_back('{err, {16'h0, e}, w ? 32'h0 : {16'hFFFF, m}});
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {16'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	function automatic fpxe_pkg::fpxe_op_t mk(input logic [2:0] c, input logic md, input logic za,
			input logic zb, input logic signed [17:0] e, input logic [2:0] x);
		mk           = '0;
		mk.valid     = 1'b1;
		mk.op        = c;
		mk.mem_dst   = md;
		mk.pc_ignore = 1'b1;
		mk.sa        = sa;
		mk.sb        = sb;
		mk.za        = za;
		mk.zb        = zb;
		mk.fa        = 1'b1;
		mk.rnum      = ~(za | zb);
		mk.rs        = rs;
		mk.rexp      = e;
		mk.rsig      = {SI, x};
	endfunction : mk

	task automatic note(input logic [3:0] p, input logic [79:0] t, input logic [79:0] s);
		nq.push_back('{p, t, s});
	endtask : note

	task automatic setup(input logic [15:0] c, input logic [15:0] pre);
		apb(1'b1, fpxe_pkg::ADDR_CTL, c, 16'h0, 16'h0, 1'b0);
		apb(1'b1, fpxe_pkg::ADDR_STAT, pre, 16'h0, 16'h0, 1'b0);
		cmp_reg({16'h0, ctl_word}, {16'h0, c & fpxe_pkg::CTL_WMASK});
		sa = 1'($urandom);
		sb = 1'($urandom);
		rs = 1'($urandom);
	endtask : setup

	task automatic send(input fpxe_pkg::fpxe_op_t o);
		op <= o;
		do
			@(posedge pclk);
		while (op_ready !== 1'b1);
	endtask : send

	task automatic fin(input logic [15:0] st, input logic [15:0] sm);
		int k;
		op.valid <= 1'b0;
		k = 0;
		while (nq.size() != 0 && k < 50) begin
			@(posedge pclk);
			k++;
		end
		repeat (3) @(posedge pclk);
		cmp_reg(32'(nq.size()), 32'h0);
		cmp_reg({16'h0, stat_word & sm}, {16'h0, st & sm});
		cmp_reg({31'h0, op_ready}, 32'h1);
		nq.delete();
		apb(1'b0, fpxe_pkg::ADDR_STAT, 16'h0, st, sm, 1'b0);
	endtask : fin

	initial begin
		int i;
		i = $urandom(32'h8e0dee07);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, write masks and an unmapped address
		apb(1'b0, fpxe_pkg::ADDR_CTL, 16'h0, fpxe_pkg::CTL_RST, 16'hFFFF, 1'b0);
		apb(1'b0, fpxe_pkg::ADDR_STAT, 16'h0, fpxe_pkg::STAT_RST, 16'hFFFF, 1'b0);
		apb(1'b1, 12'h008, 16'hFFFF, 16'h0, 16'h0, 1'b1);
		apb(1'b0, 12'h008, 16'h0, 16'h0, 16'hFFFF, 1'b1);
		apb(1'b1, fpxe_pkg::ADDR_CTL, 16'hFFFF, 16'h0, 16'h0, 1'b0);
		apb(1'b0, fpxe_pkg::ADDR_CTL, 16'h0, 16'h0F3F, 16'hFFFF, 1'b0);
		apb(1'b1, fpxe_pkg::ADDR_STAT, 16'hFFFF, 16'h0, 16'h0, 1'b0);
		apb(1'b0, fpxe_pkg::ADDR_STAT, 16'h0, 16'h021D, 16'hFFFF, 1'b0);
		// Masked divide-by-zero in each dividing class, then one unmasked divide
		for (i = 0; i < 9; i++) begin
			setup(fpxe_pkg::CTL_RST, 16'h0);
			case (i % 3)
				0: begin
					note(4'h8, {sa ^ sb, EI, SI}, 80'h0);
					send(mk(fpxe_pkg::OP_DIV, 1'b0, 1'b0, 1'b1, 18'sh0, 3'h0));
				end
				1: begin
					note(4'h8, {~sa, EI, SI}, 80'h0);
					send(mk(fpxe_pkg::OP_LOG, 1'b0, 1'b0, 1'b1, 18'sh0, 3'h0));
				end
				default: begin
					note(4'hA, {sa, 79'h0}, {1'b1, EI, SI});
					send(mk(fpxe_pkg::OP_XTRACT, 1'b0, 1'b1, 1'b0, 18'sh0, 3'h0));
				end
			endcase
			fin(16'h0004, 16'h001D);
		end
		setup(16'h037B, 16'h0);
		note(4'h1, 80'h0, 80'h0);
		send(mk(fpxe_pkg::OP_DIV, 1'b0, 1'b0, 1'b1, 18'sh0, 3'h0));
		fin(16'h0004, 16'h001D);
		// Masked overflow by rounding mode, and the largest exponent that still fits
		setup(fpxe_pkg::CTL_RST, 16'h0);
		note(4'h8, {rs, EI, SI}, 80'h0);
		send(mk(fpxe_pkg::OP_ARITH, 1'b0, 1'b0, 1'b0, 18'sh0_4000, 3'h0));
		fin(16'h0008, 16'h001D);
		setup(16'h0F7F, 16'h0);
		note(4'h8, {rs, 15'h7FFE, fpxe_pkg::MAXS_EXT}, 80'h0);
		send(mk(fpxe_pkg::OP_ARITH, 1'b0, 1'b0, 1'b0, 18'sh0_4000, 3'h0));
		fin(16'h0008, 16'h001D);
		setup(fpxe_pkg::CTL_RST, 16'h0);
		note(4'h8, {rs, 15'h7FFE, SI}, 80'h0);
		send(mk(fpxe_pkg::OP_ARITH, 1'b0, 1'b0, 1'b0, fpxe_pkg::EMAX_EXT, 3'h0));
		fin(16'h0000, 16'h001D);
		// Unmasked register overflow twice back to back, single precision selected, rounding up
		setup(16'h0837, 16'h0);
		apb(1'b0, fpxe_pkg::ADDR_CTL, 16'h0, 16'h0837, 16'hFFFF, 1'b0);
		for (i = 0; i < 2; i++) begin
			note(4'h8, {rs, 15'h1FFF, SI | {63'h0, ~rs}}, 80'h0);
			note(4'h1, 80'h0, 80'h0);
		end
		send(mk(fpxe_pkg::OP_ARITH, 1'b0, 1'b0, 1'b0, 18'sh0_4000, 3'h1));
		send(mk(fpxe_pkg::OP_ARITH, 1'b0, 1'b0, 1'b0, 18'sh0_4000, 3'h1));
		fin({6'h0, ~rs, 9'h008}, 16'h021D);
		// Unmasked memory overflow and underflow: handler only, round-up bit cleared
		setup(16'h0377, 16'h0200);
		note(4'h1, 80'h0, 80'h0);
		send(mk(fpxe_pkg::OP_FSTORE, 1'b1, 1'b0, 1'b0, 18'sh0_0080, 3'h0));
		fin(16'h0008, 16'h021D);
		setup(16'h036F, 16'h0200);
		note(4'h1, 80'h0, 80'h0);
		send(mk(fpxe_pkg::OP_FSTORE, 1'b1, 1'b0, 1'b0, -18'sh0_007F, 3'h0));
		fin(16'h0010, 16'h021D);
		// Unmasked register underflow and massive scale results
		setup(16'h036F, 16'h0);
		note(4'h8, {rs, 15'h6000, SI}, 80'h0);
		note(4'h1, 80'h0, 80'h0);
		send(mk(fpxe_pkg::OP_ARITH, 1'b0, 1'b0, 1'b0, -18'sh0_3FFF, 3'h0));
		fin(16'h0010, 16'h021D);
		setup(16'h0377, 16'h0);
		note(4'h8, {rs, EI, SI}, 80'h0);
		note(4'h1, 80'h0, 80'h0);
		send(mk(fpxe_pkg::OP_SCALE, 1'b0, 1'b0, 1'b0, 18'sh0_A000, 3'h0));
		fin(16'h0008, 16'h001D);
		setup(16'h036F, 16'h0);
		note(4'h8, {rs, 79'h0}, 80'h0);
		note(4'h1, 80'h0, 80'h0);
		send(mk(fpxe_pkg::OP_SCALE, 1'b0, 1'b0, 1'b0, -18'sh0_A000, 3'h0));
		fin(16'h0010, 16'h001D);
		// Masked underflow and integer stores: memory writes, no handler
		setup(fpxe_pkg::CTL_RST, 16'h0);
		note(4'h4, {rs, 15'h3F81, 64'h4000_0000_0000_0000}, 80'h0);
		send(mk(fpxe_pkg::OP_FSTORE, 1'b1, 1'b0, 1'b0, -18'sh0_007F, 3'h0));
		fin(16'h0010, 16'h001D);
		setup(16'h076F, 16'h0);
		note(4'h4, {rs, rs ? {fpxe_pkg::EXP_ONE, SI} : 79'h0}, 80'h0);
		send(mk(fpxe_pkg::OP_ISTORE, 1'b1, 1'b0, 1'b0, -18'sh0_0001, 3'h0));
		fin(16'h0000, 16'h001D);
		ign = 1'b1;
		setup(16'h0377, 16'h0);
		send(mk(fpxe_pkg::OP_ISTORE, 1'b1, 1'b0, 1'b0, 18'sh0_4000, 3'h0));
		fin(16'h0001, 16'h001D);
		ign = 1'b0;
		end_of_test();
	end
endmodule : fpxe_exc_test
